// ==== shared/dpa_defines.vh ====
// Constants of the dual-port request arbiter: register map, fields, timing.
// Assumes a 100 MHz device clock and a byte-addressed Avalon-MM slave.
`ifndef DPA_DEFINES_VH
`define DPA_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DPA_OFS_CTRL        4'h0
`define DPA_OFS_STAT        4'h4

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define DPA_CTRL_ASYNC_A    0
`define DPA_CTRL_ASYNC_B    1
`define DPA_CTRL_FREQ_SEL   2
`define DPA_CTRL_ECC_MODE   3
`define DPA_CTRL_BANK_LO    4
`define DPA_CTRL_BANK_HI    5
`define DPA_CTRL_INIT_GO    6
`define DPA_CTRL_RESET      6'h00

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define DPA_STAT_STRAP_A    0
`define DPA_STAT_STRAP_B    1
`define DPA_STAT_LAST_B     2
`define DPA_STAT_BUSY       3
`define DPA_STAT_PEND_A     4
`define DPA_STAT_PEND_B     5
`define DPA_STAT_INIT       6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DPA_CLK_NS          10
`define DPA_TRCD_NS         20
`define DPA_TCAS_NS         40
`define DPA_TRP_NS          60
`define DPA_TRCD_CYC        ((`DPA_TRCD_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
`define DPA_TCAS_CYC        ((`DPA_TCAS_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
`define DPA_TRP_CYC         ((`DPA_TRP_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
`define DPA_INIT_CYC        8388608

`endif

// ==== design/dpa_port.v ====
// One processor port: strap latch, optional synchroniser, request decode, queue slot.
// Assumes the strap level is valid at reset release and held there.
`default_nettype none

module dpa_port (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	// Configuration
	input  wire       async_i,
	// Port pins
	input  wire       read_req_i,
	input  wire       write_req_i,
	input  wire       port_enable_i,
	input  wire       port_control_strap_i,
	input  wire [1:0] bank_i,
	// Arbiter side
	input  wire       grant_i,
	output reg        status_mode_o,
	output reg        pend_o,
	output reg        wr_o,
	output reg  [1:0] bank_o
);

	reg        armed_q;
	reg  [5:0] sync1_q;
	reg  [5:0] sync2_q;
	reg        prev_q;
	wire [5:0] raw;
	wire [5:0] sel;
	wire       req_rd;
	wire       req_wr;
	wire       start;

	// ----------------------------------------------------------------
	// Strap latch and synchroniser
	// ----------------------------------------------------------------
	assign raw = {bank_i, port_control_strap_i, port_enable_i, write_req_i, read_req_i};
	assign sel = async_i ? sync2_q : raw;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed_q       <= 1'b0;
			status_mode_o <= 1'b0;
			sync1_q       <= 6'h00;
			sync2_q       <= 6'h00;
		end else if (ce_i) begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			if (!armed_q) begin
				armed_q       <= 1'b1;
				status_mode_o <= port_control_strap_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Decode: status lines or discrete commands
	// ----------------------------------------------------------------
	// Status: sel[3] is status line 2, sel[0] line 1, sel[1] line 0
	assign req_rd = sel[2] & (status_mode_o ? (sel[3] & ~sel[0] & sel[1])
	                                        : (sel[0] & ~sel[3]));
	assign req_wr = sel[2] & (status_mode_o ? (sel[3] & sel[0] & ~sel[1])
	                                        : (sel[1] & ~sel[3]));
	assign start  = (req_rd | req_wr) & ~prev_q;

	// ----------------------------------------------------------------
	// Queue slot
	// ----------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
			pend_o <= 1'b0;
			wr_o   <= 1'b0;
			bank_o <= 2'h0;
		end else if (ce_i) begin
			prev_q <= req_rd | req_wr;
			if (start && (!pend_o || grant_i)) begin
				pend_o <= 1'b1;
				wr_o   <= req_wr;
				bank_o <= sel[5:4];
			end else if (grant_i) begin
				pend_o <= 1'b0;
			end
		end
	end

endmodule // dpa_port

`default_nettype wire

// ==== design/dpa_arbiter.v ====
// Dual-port DRAM request arbiter: two port front ends, bank timing, strobes.
// Assumes refresh requests and ECC error flags come from neighbouring logic.
//
// How it works
// - Port B mode strap caught at reset release
// - Port A mode strap caught at reset release
// - Port A read/write pins: commands or status
// - Port B write pin: command or status line 0
// - Port B read pin: command or status line 1
// - Requests count only while port enable high
// - Each port configured independently
// - Each port sync or async to its processor
// - Async ports pass inputs through synchroniser
// - Decode status lines or accept discrete commands
// - Cycle timing stretched for slower clock option
// - Arbitrate ports, route data, history priority
// - Requests during busy memory are queued
// - Four banks, each its own strobe pair
// - Bank count bits map strobes to banks
// - Different-bank cycles overlap previous precharge
// - Same-bank cycle waits for full precharge
// - ECC mode drives init and scrub controls
`default_nettype none
`include "dpa_defines.vh"

module dpa_arbiter #(
	parameter INIT_CYCLES = `DPA_INIT_CYC
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// Avalon-MM slave
	input  wire [3:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	// Port A
	input  wire        read_request_a_i,
	input  wire        write_request_a_i,
	input  wire        port_enable_a_i,
	input  wire        port_control_strap_a_i,
	// Port B
	input  wire        read_request_b_i,
	input  wire        write_request_b_i,
	input  wire        port_enable_b_i,
	input  wire        port_control_strap_b_i,
	// Bank select
	input  wire        bank_select_low_i,
	input  wire        bank_select_high_i,
	// Refresh and correction unit
	input  wire        refresh_req_i,
	input  wire        ecc_error_i,
	output reg         refresh_ack_o,
	output reg         ecc_init_o,
	output reg         ecc_scrub_o,
	output reg         ecc_writeback_o,
	// DRAM strobes and cycle info
	output reg  [3:0]  ras_n_o,
	output reg  [3:0]  cas_n_o,
	output reg         ack_a_o,
	output reg         ack_b_o,
	output reg         cyc_write_o,
	output reg         cyc_port_b_o
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RAS  = 2'h1;
	localparam [1:0] ST_CAS  = 2'h2;
	localparam [1:0] ST_WB   = 2'h3;

	localparam [1:0] K_A    = 2'h0;
	localparam [1:0] K_B    = 2'h1;
	localparam [1:0] K_INIT = 2'h2;
	localparam [1:0] K_REF  = 2'h3;

	localparam integer RCD_I  = `DPA_TRCD_CYC;
	localparam integer CAS_I  = `DPA_TCAS_CYC;
	localparam integer RP_I   = `DPA_TRP_CYC;
	localparam integer INIT_I = INIT_CYCLES - 1;

	reg  [5:0]  ctrl_q;
	reg         bus_ack_q;
	reg  [1:0]  state_q;
	reg  [1:0]  kind_q;
	reg  [1:0]  bank_q;
	reg  [3:0]  mask_q;
	reg  [3:0]  cnt_q;
	reg         last_b_q;
	reg         ref_pend_q;
	reg         init_busy_q;
	reg  [23:0] init_cnt_q;
	reg  [1:0]  init_bank_q;

	wire        pend_a;
	wire        pend_b;
	wire        wr_a;
	wire        wr_b;
	wire [1:0]  bank_a;
	wire [1:0]  bank_b;
	wire        mode_a;
	wire        mode_b;
	wire [1:0]  bank_sel;
	wire [1:0]  bank_cnt;
	wire        ecc_mode;
	wire [3:0]  free;
	wire        bus_req;
	wire [31:0] stat_word;
	wire [3:0]  t_rcd;
	wire [3:0]  t_cas;
	wire [3:0]  t_rp;

	reg         go_a;
	reg         go_b;
	reg         go_init;
	reg         go_ref;
	reg         finish;

	// ----------------------------------------------------------------
	// Ports
	// ----------------------------------------------------------------
	assign bank_sel = {bank_select_high_i, bank_select_low_i};

	dpa_port u_port_a (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.ce_i                 (ce_i),
		.async_i              (ctrl_q[`DPA_CTRL_ASYNC_A]),
		.read_req_i           (read_request_a_i),
		.write_req_i          (write_request_a_i),
		.port_enable_i        (port_enable_a_i),
		.port_control_strap_i (port_control_strap_a_i),
		.bank_i               (bank_sel),
		.grant_i              (go_a),
		.status_mode_o        (mode_a),
		.pend_o               (pend_a),
		.wr_o                 (wr_a),
		.bank_o               (bank_a)
	);

	dpa_port u_port_b (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.ce_i                 (ce_i),
		.async_i              (ctrl_q[`DPA_CTRL_ASYNC_B]),
		.read_req_i           (read_request_b_i),
		.write_req_i          (write_request_b_i),
		.port_enable_i        (port_enable_b_i),
		.port_control_strap_i (port_control_strap_b_i),
		.bank_i               (bank_sel),
		.grant_i              (go_b),
		.status_mode_o        (mode_b),
		.pend_o               (pend_b),
		.wr_o                 (wr_b),
		.bank_o               (bank_b)
	);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	assign bus_req           = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = bus_req & ~(bus_ack_q & ce_i);
	assign stat_word = {25'h0000000, init_busy_q, pend_b, pend_a,
	                    (state_q != ST_IDLE), last_b_q, mode_b, mode_a};

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_ack_q      <= 1'b0;
			avs_readdata_o <= 32'h00000000;
			ctrl_q         <= `DPA_CTRL_RESET;
		end else if (ce_i) begin
			bus_ack_q <= bus_req & ~bus_ack_q;
			if (bus_req && !bus_ack_q) begin
				case (avs_address_i)
					`DPA_OFS_CTRL: avs_readdata_o <= {26'h0000000, ctrl_q};
					`DPA_OFS_STAT: avs_readdata_o <= stat_word;
					default:       avs_readdata_o <= 32'h00000000;
				endcase
			end
			if (avs_write_i && bus_ack_q && avs_byteenable_i[0] &&
			    avs_address_i == `DPA_OFS_CTRL) begin
				ctrl_q <= avs_writedata_i[5:0];
			end
		end
	end

	assign bank_cnt = {ctrl_q[`DPA_CTRL_BANK_HI], ctrl_q[`DPA_CTRL_BANK_LO]};
	assign ecc_mode = ctrl_q[`DPA_CTRL_ECC_MODE];

	// ----------------------------------------------------------------
	// Timing, doubled for the slow clock option
	// ----------------------------------------------------------------
	assign t_rcd = ctrl_q[`DPA_CTRL_FREQ_SEL] ? RCD_I[2:0] << 1 : RCD_I[3:0];
	assign t_cas = ctrl_q[`DPA_CTRL_FREQ_SEL] ? CAS_I[2:0] << 1 : CAS_I[3:0];
	assign t_rp  = ctrl_q[`DPA_CTRL_FREQ_SEL] ? RP_I[2:0] << 1 : RP_I[3:0];

	// Strobe pairs allotted to a bank by the bank count bits
	function [3:0] strobe_mask;
		input [1:0] cnt;
		input [1:0] bank;
		begin
			case (cnt)
				2'h0:    strobe_mask = (bank == 2'h0) ? 4'hf : 4'h0;
				2'h1:    strobe_mask = (bank == 2'h0) ? 4'h3 :
				                       (bank == 2'h1) ? 4'hc : 4'h0;
				2'h2:    strobe_mask = (bank == 2'h3) ? 4'h0 : (4'h1 << bank);
				default: strobe_mask = 4'h1 << bank;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Bank precharge timers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_bank
			reg  [3:0]  pc_q;
			reg  [3:0]  pc_d;
			assign free[g] = (pc_q == 4'h0) && !(state_q != ST_IDLE && bank_q == g);
			always @* begin
				pc_d = (pc_q != 4'h0) ? pc_q - 4'h1 : 4'h0;
				if (finish && (kind_q == K_REF || bank_q == g)) begin
					pc_d = t_rp;
				end
			end
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					pc_q <= 4'h0;
				end else if (ce_i) begin
					pc_q <= pc_d;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	always @* begin
		go_a    = 1'b0;
		go_b    = 1'b0;
		go_init = 1'b0;
		go_ref  = 1'b0;
		finish  = 1'b0;
		if (ce_i && (state_q == ST_CAS || state_q == ST_WB) && cnt_q == 4'h1) begin
			finish = !(state_q == ST_CAS && kind_q == K_REF && ecc_mode && ecc_error_i);
		end
		if (ce_i && state_q == ST_IDLE) begin
			if (ref_pend_q) begin
				go_ref = (free == 4'hf);
			end else if (init_busy_q) begin
				go_init = free[init_bank_q];
			end else begin
				if (pend_a && free[bank_a] && pend_b && free[bank_b]) begin
					go_a = last_b_q;
					go_b = !last_b_q;
				end else begin
					go_a = pend_a && free[bank_a];
					go_b = pend_b && free[bank_b];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// RAM cycle sequencer
	// ----------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q         <= ST_IDLE;
			kind_q          <= K_A;
			bank_q          <= 2'h0;
			mask_q          <= 4'h0;
			cnt_q           <= 4'h0;
			last_b_q        <= 1'b0;
			ras_n_o         <= 4'hf;
			cas_n_o         <= 4'hf;
			ack_a_o         <= 1'b0;
			ack_b_o         <= 1'b0;
			refresh_ack_o   <= 1'b0;
			cyc_write_o     <= 1'b0;
			cyc_port_b_o    <= 1'b0;
			ecc_scrub_o     <= 1'b0;
			ecc_writeback_o <= 1'b0;
		end else if (ce_i) begin
			ack_a_o       <= 1'b0;
			ack_b_o       <= 1'b0;
			refresh_ack_o <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (go_a || go_b || go_init || go_ref) begin
						state_q <= ST_RAS;
						cnt_q   <= t_rcd;
						if (go_ref) begin
							kind_q      <= K_REF;
							mask_q      <= 4'hf;
							ras_n_o     <= 4'h0;
							ecc_scrub_o <= ecc_mode;
						end else if (go_init) begin
							kind_q      <= K_INIT;
							bank_q      <= init_bank_q;
							mask_q      <= strobe_mask(bank_cnt, init_bank_q);
							ras_n_o     <= ~strobe_mask(bank_cnt, init_bank_q);
							cyc_write_o <= 1'b1;
						end else begin
							kind_q       <= go_b ? K_B : K_A;
							bank_q       <= go_b ? bank_b : bank_a;
							mask_q       <= strobe_mask(bank_cnt, go_b ? bank_b : bank_a);
							ras_n_o      <= ~strobe_mask(bank_cnt, go_b ? bank_b : bank_a);
							cyc_write_o  <= go_b ? wr_b : wr_a;
							cyc_port_b_o <= go_b;
							last_b_q     <= go_b;
						end
					end
				end
				ST_RAS: begin
					if (cnt_q == 4'h1) begin
						state_q <= ST_CAS;
						cnt_q   <= t_cas;
						if (kind_q != K_REF || ecc_mode) begin
							cas_n_o <= ~mask_q;
						end
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_CAS, ST_WB: begin
					if (cnt_q != 4'h1) begin
						cnt_q <= cnt_q - 4'h1;
					end else if (!finish) begin
						state_q         <= ST_WB;
						cnt_q           <= t_cas;
						ecc_writeback_o <= 1'b1;
					end else begin
						state_q         <= ST_IDLE;
						ras_n_o         <= 4'hf;
						cas_n_o         <= 4'hf;
						ecc_scrub_o     <= 1'b0;
						ecc_writeback_o <= 1'b0;
						cyc_write_o     <= 1'b0;
						ack_a_o         <= (kind_q == K_A);
						ack_b_o         <= (kind_q == K_B);
						refresh_ack_o   <= (kind_q == K_REF);
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Refresh request latch and ECC memory initialisation
	// ----------------------------------------------------------------
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_pend_q  <= 1'b0;
			init_busy_q <= 1'b0;
			init_cnt_q  <= 24'h000000;
			init_bank_q <= 2'h0;
			ecc_init_o  <= 1'b0;
		end else if (ce_i) begin
			if (refresh_req_i) begin
				ref_pend_q <= 1'b1;
			end else if (go_ref) begin
				ref_pend_q <= 1'b0;
			end
			if (go_init) begin
				init_bank_q <= init_bank_q + 2'h1;
			end
			if (!init_busy_q && ecc_mode && bus_ack_q && avs_write_i &&
			    avs_byteenable_i[0] && avs_address_i == `DPA_OFS_CTRL &&
			    avs_writedata_i[`DPA_CTRL_INIT_GO]) begin
				init_busy_q <= 1'b1;
				ecc_init_o  <= 1'b1;
				init_cnt_q  <= INIT_I[23:0];
			end else if (init_busy_q) begin
				if (init_cnt_q == 24'h000000) begin
					init_busy_q <= 1'b0;
					ecc_init_o  <= 1'b0;
				end else begin
					init_cnt_q <= init_cnt_q - 24'h000001;
				end
			end
		end
	end

endmodule // dpa_arbiter

`default_nettype wire

// ==== sim/dpa_cpu_model.sv ====
// Processor port model: drives one port's request pins from a bench go level.
// Assumes the arbiter answers each accepted request with a one-cycle ack pulse.
`default_nettype none

module dpa_cpu_model (
	// Clock, reset, bench control
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic go_i,
	input  wire logic wr_i,
	input  wire logic en_i,
	input  wire logic status_i,
	input  wire logic ack_i,
	// Port pins
	output var logic  rd_o,
	output var logic  wr_o,
	output var logic  pe_o,
	output wire logic ctl_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic go_q;

	// Control pin carries status line 2 in status mode, tied low otherwise
	assign ctl_o = status_i;

	// ----------------
	// Request pins
	// ----------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			go_q <= 1'b0;
			pe_o <= 1'b0;
			rd_o <= status_i;
			wr_o <= status_i;
		end else begin
			go_q <= go_i;
			if (go_i && !go_q) begin
				pe_o <= en_i;
				rd_o <= status_i ? wr_i : !wr_i;
				wr_o <= status_i ? !wr_i : wr_i;
			end else if (ack_i || !go_i) begin
				pe_o <= 1'b0;
				rd_o <= status_i;
				wr_o <= status_i;
			end
		end
	end
endmodule // dpa_cpu_model

`default_nettype wire

// ==== sim/dpa_arbiter_asserts.sv ====
// Checker of the arbiter: strobe shape, grant routing, bus answer.
// Assumes it is bound into the arbiter and sees only its ports.
`default_nettype none

module dpa_arbiter_asserts #(
	parameter INIT_CYCLES = 64
) (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Bus
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	// DRAM side
	input wire logic [3:0] ras_n_o,
	input wire logic [3:0] cas_n_o,
	input wire logic       ack_a_o,
	input wire logic       ack_b_o,
	input wire logic       cyc_port_b_o,
	input wire logic       refresh_ack_o,
	input wire logic       ecc_init_o,
	input wire logic       ecc_scrub_o
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ----------------
	// Assertions
	// ----------------
	ack_a_route_a: assert property (ack_a_o |-> !cyc_port_b_o)
		else $error("ack A during port B cycle");
	ack_b_route_a: assert property (ack_b_o |-> cyc_port_b_o)
		else $error("ack B during port A cycle");
	ack_single_a: assert property ((ack_a_o || ack_b_o) |=> !(ack_a_o || ack_b_o))
		else $error("ack longer than one cycle");
	cas_in_ras_a: assert property ((cas_n_o | ~ras_n_o) == 4'hf)
		else $error("column strobe without row strobe");
	ras_to_cas_a: assert property ($fell(cas_n_o[0]) |-> $past(ras_n_o[0], 2) == 1'b0)
		else $error("row to column delay short");
	cas_width_a: assert property ($fell(cas_n_o[0]) |-> !cas_n_o[0] [*4])
		else $error("column strobe too short");
	precharge_a: assert property ($rose(ras_n_o[0]) |-> ras_n_o[0] [*6])
		else $error("precharge cut short");
	ras_map_a: assert property (ras_n_o inside {4'hf, 4'h0, 4'hc, 4'h3, 4'he, 4'hd, 4'hb, 4'h7})
		else $error("row strobe pattern not a bank group");
	refresh_pulse_a: assert property (refresh_ack_o |=> !refresh_ack_o)
		else $error("refresh ack longer than one cycle");
	bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");

	// Main scenarios
	cover property (ack_b_o);
	cover property (ecc_init_o);
	cover property (ecc_scrub_o);
endmodule // dpa_arbiter_asserts

bind dpa_arbiter dpa_arbiter_asserts #(.INIT_CYCLES(INIT_CYCLES)) u_asserts (.*);

`default_nettype wire

// ==== sim/dpa_arbiter_tb.sv ====
// Testbench of the arbiter: strap modes, bank strobes, contention, ECC hooks.
// Assumes the checker is bound in and two processor models drive the ports.
`default_nettype none
`include "dpa_defines.vh"

module dpa_arbiter_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i = 1'b0, rst_i = 1'b1, rfq = 1'b0, eer = 1'b0;
	logic        go_a = 1'b0, go_b = 1'b0, wr_c = 1'b0, en_c = 1'b0;
	logic        strap_a = 1'b0, strap_b = 1'b1, rd_a, wr_a, pe_a, ct_a, rd_b, wr_b, pe_b, ct_b;
	logic        rd = 1'b0, wr = 1'b0, wreq, ack_a, ack_b, cwr, cpb, wr_seen;
	logic        rack, einit, escrub, ewb, scrub_seen = 1'b0, wb_seen = 1'b0, init_seen = 1'b0;
	logic [1:0]  bank_sel = 2'h0;
	logic [3:0]  adr = 4'h0, be = 4'hf, ras_n, cas_n, rv, ras_seen = 4'hf;
	logic [31:0] wd = 32'h0, rdata, q;
	int          err_total = 0, total_checks = 0, la, lb, lf, lbf, gs;

	dpa_arbiter #(.INIT_CYCLES(64)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.read_request_a_i(rd_a), .write_request_a_i(wr_a), .port_enable_a_i(pe_a),
		.port_control_strap_a_i(ct_a), .read_request_b_i(rd_b), .write_request_b_i(wr_b),
		.port_enable_b_i(pe_b), .port_control_strap_b_i(ct_b),
		.bank_select_low_i(bank_sel[0]), .bank_select_high_i(bank_sel[1]),
		.refresh_req_i(rfq), .ecc_error_i(eer), .refresh_ack_o(rack), .ecc_init_o(einit),
		.ecc_scrub_o(escrub), .ecc_writeback_o(ewb), .ras_n_o(ras_n), .cas_n_o(cas_n),
		.ack_a_o(ack_a), .ack_b_o(ack_b), .cyc_write_o(cwr), .cyc_port_b_o(cpb));
	dpa_cpu_model cpu_a (.clk_i(clk_i), .rst_i(rst_i), .go_i(go_a), .wr_i(wr_c), .en_i(en_c),
		.status_i(strap_a), .ack_i(ack_a), .rd_o(rd_a), .wr_o(wr_a), .pe_o(pe_a), .ctl_o(ct_a));
	dpa_cpu_model cpu_b (.clk_i(clk_i), .rst_i(rst_i), .go_i(go_b), .wr_i(wr_c), .en_i(en_c),
		.status_i(strap_b), .ack_i(ack_b), .rd_o(rd_b), .wr_o(wr_b), .pe_o(pe_b), .ctl_o(ct_b));

	initial forever #5 clk_i = ~clk_i;

	// Strobes and cycle kind seen while a cycle runs
	always @(posedge clk_i) begin
		if (ras_n !== 4'hf) begin
			ras_seen <= ras_seen & ras_n;
			wr_seen <= cwr;
		end
		scrub_seen <= scrub_seen | (escrub === 1'b1);
		wb_seen <= wb_seen | (ewb === 1'b1);
		init_seen <= init_seen | (einit === 1'b1);
	end

	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_i);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdata;
		if (n >= 50) err_total++;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic run(input logic ga, gb, w, en, stag, input logic [1:0] ba, bb);
		la = 0;
		lb = 0;
		ras_seen = 4'hf;
		wr_seen = 1'bx;
		@(posedge clk_i);
		go_a <= ga;
		go_b <= gb & !stag;
		wr_c <= w;
		en_c <= en;
		bank_sel <= ba;
		for (int i = 1; i < 90 && (la == 0 && ga || lb == 0 && gb); i++) begin
			@(posedge clk_i);
			if (i == 2 && stag) begin
				go_b <= gb;
				bank_sel <= bb;
			end
			if (ack_a === 1'b1) la = i;
			if (ack_b === 1'b1) lb = i;
		end
		go_a <= 1'b0;
		go_b <= 1'b0;
		repeat (16) @(posedge clk_i);
	endtask

	function automatic logic [3:0] ras_exp(input logic [1:0] rb, input logic [1:0] bs);
		case (rb)
			2'h0: return (bs == 2'h0) ? 4'h0 : 4'hf;
			2'h1: return (bs == 2'h0) ? 4'hc : (bs == 2'h1) ? 4'h3 : 4'hf;
			2'h2: return (bs == 2'h3) ? 4'hf : ~(4'h1 << bs);
			default: return ~(4'h1 << bs);
		endcase
	endfunction

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		print_verdict();
	end

	// ----------------
	// Scenarios
	// ----------------
	initial begin
		void'($urandom(70089));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		bus(1'b0, `DPA_OFS_CTRL, 32'h0);
		chk("ctrl_reset", q, 32'h0);
		bus(1'b0, `DPA_OFS_STAT, 32'h0);
		chk("straps", q[1:0], 2'h2);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped", q, 32'h0);
		for (int m = 0; m < 16; m++) begin
			bus(1'b1, `DPA_OFS_CTRL, {26'h0, m[3:2], 4'h0});
			run(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, m[1:0], 2'h0);
			chk("ras_map", ras_seen, ras_exp(m[3:2], m[1:0]));
		end
		be <= 4'h0;
		bus(1'b1, `DPA_OFS_CTRL, 32'h0);
		be <= 4'hf;
		bus(1'b0, `DPA_OFS_CTRL, 32'h0);
		chk("be_ignored", q, 32'h30);
		for (int k = 0; k < 8; k++) begin
			rv = 4'($urandom);
			run(!rv[0], rv[0], rv[1], 1'b1, 1'b0, rv[3:2], rv[3:2]);
			chk("ack_port", rv[0] ? lb != 0 : la != 0, 1'b1);
			chk("cyc_write", wr_seen, rv[1]);
		end
		run(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		lf = la;
		run(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		chk("b_first", lb != 0 && lb < la, 1'b1);
		run(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		run(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0);
		chk("a_first", la != 0 && la < lb, 1'b1);
		bus(1'b0, `DPA_OFS_STAT, 32'h0);
		chk("last_b", q[2], 1'b1);
		run(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 2'h0);
		gs = lb - la;
		run(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 2'h1);
		chk("interleave", la != 0 && lb - la < gs, 1'b1);
		run(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0);
		chk("no_enable", la + lb, 32'h0);
		run(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		lbf = lb;
		bus(1'b1, `DPA_OFS_CTRL, 32'h34);
		run(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		chk("slow_clock", la > lf, 1'b1);
		bus(1'b1, `DPA_OFS_CTRL, 32'h31);
		run(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		chk("async_a", la > lf, 1'b1);
		run(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		chk("sync_b", lb, lbf);
		bus(1'b1, `DPA_OFS_CTRL, 32'h32);
		run(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		chk("async_b", lb > lbf, 1'b1);
		rst_i <= 1'b1;
		strap_a <= 1'b1;
		strap_b <= 1'b0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		bus(1'b0, `DPA_OFS_STAT, 32'h0);
		chk("straps2", q[1:0], 2'h1);
		bus(1'b1, `DPA_OFS_CTRL, 32'h30);
		for (int w = 0; w < 4; w++) begin
			run(!w[1], w[1], w[0], 1'b1, 1'b0, 2'h1, 2'h1);
			chk("mode_kind", wr_seen, w[0]);
		end
		bus(1'b1, `DPA_OFS_CTRL, 32'h38);
		bus(1'b1, `DPA_OFS_CTRL, 32'h78);
		for (int i = 0; i < 5000 && !(init_seen && einit === 1'b0); i++) @(posedge clk_i);
		chk("init_run", init_seen, 1'b1);
		bus(1'b0, `DPA_OFS_STAT, 32'h0);
		chk("init_done", q[6], 1'b0);
		eer <= 1'b1;
		rfq <= 1'b1;
		@(posedge clk_i);
		rfq <= 1'b0;
		for (int i = 0; i < 300 && rack !== 1'b1; i++) @(posedge clk_i);
		chk("scrub", {scrub_seen, wb_seen, rack}, 3'h7);
		eer <= 1'b0;
		repeat (20) @(posedge clk_i);
		print_verdict();
	end
endmodule // dpa_arbiter_tb

`default_nettype wire
